// [tsrb_bank.sv]
`timescale 1ns/1ps
module tsrb_bank (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // byte port from the serial protocol engine
  input  wire logic        xfer_start,
  input  wire logic        xfer_is_read,
  input  wire logic        wr_byte_valid,
  input  wire logic [7:0]  wr_byte,
  input  wire logic        rd_byte_req,
  input  wire logic        xfer_stop,
  output logic      [7:0]  rd_byte,
  output logic             rd_byte_valid,
  // converter
  input  wire logic        conv_done,
  input  wire logic [10:0] conv_result,
  output logic             conv_enable,
  // open-drain alert pin
  output logic             alert_output_o,
  output logic             alert_output_oe,
  // observation
  output logic             alert_active
);

  typedef struct packed {
    logic [1:0]              pointer;
    logic [7:0]              settings;
    logic [10:0]             measured;
    logic [8:0]              upper_lim;
    logic [8:0]              release_lim;
    tsrb_pkg::tsrb_phase_e   phase;
    logic                    reading;
    logic [7:0]              rd_data;
    logic                    rd_valid;
    logic                    alarm;
    logic                    arm_release;
    logic [2:0]              faults;
  } tsrb_state_s;

  tsrb_state_s st_r;
  tsrb_state_s st_nxt;

  function automatic logic [2:0] tsrb_trip_count(input logic [1:0] code);
    unique case (code)
      2'h0: tsrb_trip_count = tsrb_pkg::TRIP_COUNT_1;
      2'h1: tsrb_trip_count = tsrb_pkg::TRIP_COUNT_2;
      2'h2: tsrb_trip_count = tsrb_pkg::TRIP_COUNT_4;
      2'h3: tsrb_trip_count = tsrb_pkg::TRIP_COUNT_6;
    endcase
  endfunction

  function automatic logic [7:0] tsrb_read_byte(input tsrb_state_s s, input logic low);
    logic [15:0] word;
    word = 16'h0000;
    unique case (s.pointer)
      // measurement alignment, low five bits zero
      tsrb_pkg::PTR_MEASURE:  word = {s.measured, 5'h00};
      tsrb_pkg::PTR_SETTINGS: word = {s.settings, s.settings};
      // limit alignment, low seven bits zero
      tsrb_pkg::PTR_RELEASE:  word = {s.release_lim, 7'h00};
      tsrb_pkg::PTR_OVER:     word = {s.upper_lim, 7'h00};
    endcase
    tsrb_read_byte = low ? word[7:0] : word[15:8];
  endfunction

  logic       shutdown;
  logic [8:0] meas9;
  logic       over_hit;
  logic       under_hit;
  logic       trip_cond;
  logic [2:0] trip_need;
  logic       pin_level;

  assign shutdown  = st_r.settings[tsrb_pkg::CFG_SHUTDOWN];
  assign meas9     = conv_result[10:2];
  assign over_hit  = $signed(meas9) > $signed(st_r.upper_lim);
  assign under_hit = $signed(meas9) < $signed(st_r.release_lim);
  assign trip_need = tsrb_trip_count(st_r.settings[tsrb_pkg::CFG_TRIP_HI:tsrb_pkg::CFG_TRIP_LO]);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    trip_cond       = 1'b0;

    if (xfer_start) begin
      st_nxt.reading = xfer_is_read;
      st_nxt.phase   = xfer_is_read ? tsrb_pkg::TSRB_HIGH_BYTE : tsrb_pkg::TSRB_POINTER;
    end else if (xfer_stop) begin
      // a stop after any byte count ends the transfer
      st_nxt.phase = tsrb_pkg::TSRB_POINTER;
    end else if (wr_byte_valid && !st_r.reading) begin
      unique case (st_r.phase)
        tsrb_pkg::TSRB_POINTER: begin
          st_nxt.pointer = wr_byte[1:0];
          st_nxt.phase   = tsrb_pkg::TSRB_HIGH_BYTE;
        end
        tsrb_pkg::TSRB_HIGH_BYTE: begin
          st_nxt.phase = tsrb_pkg::TSRB_LOW_BYTE;
          unique case (st_r.pointer)
            // whole byte stored, reserved bits too
            tsrb_pkg::PTR_SETTINGS: st_nxt.settings = wr_byte;
            tsrb_pkg::PTR_RELEASE:  st_nxt.release_lim = {wr_byte, st_r.release_lim[0]};
            tsrb_pkg::PTR_OVER:     st_nxt.upper_lim = {wr_byte, st_r.upper_lim[0]};
            tsrb_pkg::PTR_MEASURE:  st_nxt.measured = st_r.measured;
          endcase
        end
        tsrb_pkg::TSRB_LOW_BYTE: begin
          if (st_r.pointer == tsrb_pkg::PTR_RELEASE) begin
            st_nxt.release_lim[0] = wr_byte[7];
          end
          if (st_r.pointer == tsrb_pkg::PTR_OVER) begin
            st_nxt.upper_lim[0] = wr_byte[7];
          end
          if (st_r.pointer == tsrb_pkg::PTR_SETTINGS) begin
            st_nxt.settings = wr_byte;
          end
        end
      endcase
    end else if (rd_byte_req && st_r.reading) begin
      // high byte first, then low byte, limits alike
      st_nxt.rd_data  = tsrb_read_byte(st_r, st_r.phase == tsrb_pkg::TSRB_LOW_BYTE);
      st_nxt.rd_valid = 1'b1;
      st_nxt.phase    = (st_r.phase == tsrb_pkg::TSRB_LOW_BYTE) ? tsrb_pkg::TSRB_HIGH_BYTE
                                                                : tsrb_pkg::TSRB_LOW_BYTE;
    end

    // latched alarm cleared by any register read
    if (rd_byte_req && st_r.reading && st_r.settings[tsrb_pkg::CFG_BEHAVIOUR]) begin
      st_nxt.alarm = 1'b0;
    end
    // entering power-down clears a latched alarm
    if (st_nxt.settings[tsrb_pkg::CFG_SHUTDOWN] && !shutdown && st_r.settings[tsrb_pkg::CFG_BEHAVIOUR]) begin
      st_nxt.alarm = 1'b0;
    end

    if (conv_done && !shutdown) begin
      st_nxt.measured = conv_result;
      if (st_r.settings[tsrb_pkg::CFG_BEHAVIOUR]) begin
        // latched mode alternates over and release trips
        trip_cond = st_r.alarm ? 1'b0 : (st_r.arm_release ? under_hit : over_hit);
      end else begin
        // comparator mode tracks the hysteresis band
        trip_cond = st_r.alarm ? under_hit : over_hit;
      end
      if (!trip_cond) begin
        st_nxt.faults = 3'h0;
      end else if (st_r.faults + 3'h1 >= trip_need) begin
        st_nxt.faults = 3'h0;
        if (st_r.settings[tsrb_pkg::CFG_BEHAVIOUR]) begin
          // set wins over a same-cycle read clear
          st_nxt.alarm       = 1'b1;
          st_nxt.arm_release = ~st_r.arm_release;
        end else begin
          st_nxt.alarm = ~st_r.alarm;
        end
      end else begin
        st_nxt.faults = st_r.faults + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.pointer     <= tsrb_pkg::PTR_RST;
      st_r.settings    <= tsrb_pkg::CFG_RST;
      st_r.measured    <= tsrb_pkg::MEAS_RST;
      st_r.upper_lim   <= tsrb_pkg::OVER_RST[15:7];
      st_r.release_lim <= tsrb_pkg::RELEASE_RST[15:7];
      st_r.phase       <= tsrb_pkg::TSRB_POINTER;
      st_r.reading     <= 1'b0;
      st_r.rd_data     <= 8'h00;
      st_r.rd_valid    <= 1'b0;
      st_r.alarm       <= 1'b0;
      st_r.arm_release <= 1'b0;
      st_r.faults      <= 3'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conv_enable   = ~shutdown;
  assign rd_byte       = st_r.rd_data;
  assign rd_byte_valid = st_r.rd_valid;
  assign alert_active  = st_r.alarm;

  assign pin_level       = st_r.alarm ? st_r.settings[tsrb_pkg::CFG_POLARITY]
                                      : ~st_r.settings[tsrb_pkg::CFG_POLARITY];
  // open-drain: only ever pulls low
  assign alert_output_o  = 1'b0;
  assign alert_output_oe = ~pin_level;

endmodule

// [tsrb_pkg.sv]
package tsrb_pkg;
  localparam logic [1:0]  PTR_MEASURE    = 2'h0;
  localparam logic [1:0]  PTR_SETTINGS   = 2'h1;
  localparam logic [1:0]  PTR_RELEASE    = 2'h2;
  localparam logic [1:0]  PTR_OVER       = 2'h3;
  localparam logic [1:0]  PTR_RST        = 2'h0;

  localparam int          CFG_SHUTDOWN   = 0;
  localparam int          CFG_BEHAVIOUR  = 1;
  localparam int          CFG_POLARITY   = 2;
  localparam int          CFG_TRIP_LO    = 3;
  localparam int          CFG_TRIP_HI    = 4;
  localparam logic [7:0]  CFG_RST        = 8'h00;

  localparam logic [15:0] OVER_RST       = 16'h5000;
  localparam logic [15:0] RELEASE_RST    = 16'h4B00;
  localparam logic [10:0] MEAS_RST       = 11'h000;

  localparam logic [2:0]  TRIP_COUNT_1   = 3'h1;
  localparam logic [2:0]  TRIP_COUNT_2   = 3'h2;
  localparam logic [2:0]  TRIP_COUNT_4   = 3'h4;
  localparam logic [2:0]  TRIP_COUNT_6   = 3'h6;

  typedef enum logic [1:0] {
    TSRB_POINTER,
    TSRB_HIGH_BYTE,
    TSRB_LOW_BYTE
  } tsrb_phase_e;
endpackage

// [tsrb_properties.sv]
`timescale 1ns/1ps
module tsrb_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // watched ports
  input wire logic       wr_byte_valid,
  input wire logic       rd_byte_req,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_byte_valid,
  input wire logic       conv_done,
  input wire logic       conv_enable,
  input wire logic       alert_output_o,
  input wire logic       alert_output_oe,
  input wire logic       alert_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rd_ans; rd_byte_valid |-> $past(rd_byte_req); endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("stray read byte");
  property p_rd_hold; !$past(rd_byte_req) |-> $stable(rd_byte); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
  property p_od_low; !alert_output_o; endproperty
  a_od_low: assert property (p_od_low) else $error("pin driven high");
  property p_pwr_src; $changed(conv_enable) |-> $past(wr_byte_valid); endproperty
  a_pwr_src: assert property (p_pwr_src) else $error("power mode moved");
  property p_oe_src; $changed(alert_output_oe) |-> $changed(alert_active) || $past(wr_byte_valid); endproperty
  a_oe_src: assert property (p_oe_src) else $error("pin moved alone");
  property p_rise; $rose(alert_active) |-> $past(conv_done) || $past(conv_done, 2); endproperty
  a_rise: assert property (p_rise) else $error("alarm without conversion");
  property p_fall;
    $fell(alert_active) |-> $past(conv_done || rd_byte_req || wr_byte_valid) || $past(conv_done, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("alarm dropped alone");
  property p_rst; $fell(rst) |-> conv_enable && !alert_active && !alert_output_oe && !rd_byte_valid; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  cover property (rd_byte_valid);
  cover property ($rose(alert_active));
  cover property ($fell(conv_enable));
endmodule
bind tsrb_bank tsrb_checker u_tsrb_checker (.sys_clk, .rst, .wr_byte_valid, .rd_byte_req, .rd_byte,
  .rd_byte_valid, .conv_done, .conv_enable, .alert_output_o, .alert_output_oe, .alert_active);

// [tsrb_ctrl_model.sv]
`timescale 1ns/1ps
module tsrb_ctrl_model (
  // clock
  input wire logic       sys_clk,
  // byte port towards the bank
  output logic           xfer_start,
  output logic           xfer_is_read,
  output logic           wr_byte_valid,
  output logic [7:0]     wr_byte,
  output logic           rd_byte_req,
  output logic           xfer_stop,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_byte_valid
);
  initial {xfer_start, xfer_is_read, wr_byte_valid, wr_byte, rd_byte_req, xfer_stop} = '0;
  task put(input logic [4:0] s, input logic [7:0] d);
    {xfer_start, xfer_is_read, wr_byte_valid, rd_byte_req, xfer_stop} = s;
    wr_byte = d;
    @(posedge sys_clk) #1;
    {xfer_start, wr_byte_valid, rd_byte_req, xfer_stop} = '0;
    // released data shows the inverse, never a stale copy
    wr_byte = ~d;
  endtask
  task wr(input logic [1:0] p, input int n, input logic [15:0] v);
    put(5'h10, 8'h00);
    put(5'h04, {6'h00, p});
    if (n > 0) put(5'h04, v[15:8]);
    if (n > 1) put(5'h04, v[7:0]);
    put(5'h01, 8'h00);
  endtask
  task rd(input logic [1:0] p, input int n, output logic [15:0] v);
    int i, k;
    wr(p, 0, 16'h0000);
    put(5'h18, 8'h00);
    v = 16'h0000;
    for (k = 0; k < n; k++) begin
      put(5'h02, 8'h00);
      for (i = 0; i < 3 && rd_byte_valid !== 1'b1; i++) @(posedge sys_clk) #1;
      v = {v[7:0], rd_byte};
    end
    put(5'h01, 8'h00);
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        conv_done = 1'b0;
  logic [10:0] conv_result = 11'h000;
  logic        xfer_start, xfer_is_read, wr_byte_valid, rd_byte_req, xfer_stop, rd_byte_valid;
  logic        conv_enable, alert_output_o, alert_output_oe, alert_active;
  logic [7:0]  wr_byte, rd_byte, cfg;
  logic [15:0] got, ovr, rel, val;
  logic [10:0] meas;
  int          failures, checked, n, i;
  always #4 sys_clk = ~sys_clk;
  tsrb_bank u_tsrb_bank (.sys_clk, .rst, .xfer_start, .xfer_is_read, .wr_byte_valid, .wr_byte,
    .rd_byte_req, .xfer_stop, .rd_byte, .rd_byte_valid, .conv_done, .conv_result, .conv_enable,
    .alert_output_o, .alert_output_oe, .alert_active);
  tsrb_ctrl_model u_tsrb_ctrl_model (.sys_clk, .xfer_start, .xfer_is_read, .wr_byte_valid,
    .wr_byte, .rd_byte_req, .xfer_stop, .rd_byte, .rd_byte_valid);
  task report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input logic g, e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task do_reset;
    rst = 1'b1;
    repeat (10) @(posedge sys_clk) #1;
    rst = 1'b0;
    {cfg, ovr, rel, meas} = {8'h00, 16'h5000, 16'h4B00, 11'h000};
  endtask
  task rc(input logic [1:0] p);
    u_tsrb_ctrl_model.rd(p, (p == 2'h1) ? 1 : 2, got);
    case (p)
      2'h0: chk(got, {meas, 5'h00});
      2'h1: chk(got, {8'h00, cfg});
      2'h2: chk(got, rel);
      default: chk(got, ovr);
    endcase
  endtask
  task wcfg(input logic [7:0] c);
    u_tsrb_ctrl_model.wr(2'h1, 1, {c, 8'h00});
    cfg = c;
  endtask
  task wlim(input logic [1:0] p, input int k, input logic [15:0] v);
    u_tsrb_ctrl_model.wr(p, k, v);
    val = (p == 2'h3) ? ovr : rel;
    val = {v[15:8], (k > 1) ? {v[7], 7'h00} : val[7:0]};
    if (p == 2'h3) ovr = val;
    else rel = val;
  endtask
  task conv(input logic [10:0] r);
    {conv_done, conv_result} = {1'b1, r};
    @(posedge sys_clk) #1;
    {conv_done, conv_result} = {1'b0, ~r};
    if (!cfg[0]) meas = r;
  endtask
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial begin
    void'($urandom(7893));
    do_reset();
    for (i = 0; i < 4; i++) rc(i[1:0]);
    u_tsrb_ctrl_model.wr(2'h0, 2, 16'hFFFF);
    rc(2'h0);
    repeat (4) begin
      val = $urandom;
      // reserved bits kept zero by the test
      wcfg({3'h0, val[4:0]});
      rc(2'h1);
      chk1(conv_enable, !cfg[0]);
      wlim(2'h3, 2, $urandom);
      rc(2'h3);
      wlim(2'h2, 1, $urandom);
      rc(2'h2);
      val = $urandom;
      conv(val[10:0]);
      rc(2'h0);
      chk({7'h00, got[15:7]}, {7'h00, meas[10:2]});
      u_tsrb_ctrl_model.rd(2'h0, 1, got);
      chk(got, {8'h00, meas[10:3]});
    end
    do_reset();
    wlim(2'h3, 2, 16'h1900);
    wlim(2'h2, 2, 16'h1000);
    for (i = 0; i < 4; i++) begin
      n = (i == 0) ? 1 : i * 2;
      wcfg({3'h0, i[1:0], 3'h0});
      repeat (6) conv(11'h000);
      chk1(alert_active, 1'b0);
      repeat (n - 1) conv(11'h0CC);
      // same top nine bits as the limit, so no trip
      conv(11'h0CB);
      repeat (n - 1) conv(11'h0CC);
      chk1(alert_active, 1'b0);
      conv(11'h0CC);
      chk1(alert_active, 1'b1);
    end
    chk1(alert_output_oe, 1'b1);
    wcfg(8'h1C);
    chk1(alert_output_oe, 1'b0);
    do_reset();
    wcfg(8'h02);
    conv(11'h3F8);
    chk1(alert_active, 1'b1);
    rc(2'h1);
    chk1(alert_active, 1'b0);
    conv(11'h3F8);
    chk1(alert_active, 1'b0);
    conv(11'h000);
    chk1(alert_active, 1'b1);
    wcfg(8'h03);
    chk1(alert_active, 1'b0);
    conv(11'h100);
    rc(2'h0);
    report_and_stop();
  end
endmodule
